// ### rtl/cspc_clk_div.v
// card clock gate and divider: passes, stops or divides the card clock
// assumes sys_clk is the only clock; card_clk_en is a clock-enable strobe
`default_nettype none

module cspc_clk_div #(
  parameter DIV = 16
) (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire run,
  input  wire slow,
  output reg  card_clk_en
);
  localparam CW = 5;
  reg [CW-1:0] count;

  // strobe every cycle when running, every DIV cycles when slow, never when stopped
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count       <= {CW{1'b0}};
      card_clk_en <= 1'b0;
    end else if (run) begin
      count       <= {CW{1'b0}};
      card_clk_en <= 1'b1;
    end else if (slow) begin
      if (count == DIV[CW-1:0] - 5'h01) begin
        count       <= {CW{1'b0}};
        card_clk_en <= 1'b1;
      end else begin
        count       <= count + 5'h01;
        card_clk_en <= 1'b0;
      end
    end else begin
      count       <= {CW{1'b0}};
      card_clk_en <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ### rtl/cspc_consts.vh
// register offsets, field positions, reset values and divider figures
// for the card socket clock and power control block
// assumes inclusion by bare name from the design files
`ifndef CSPC_CONSTS_VH
`define CSPC_CONSTS_VH

// register byte offsets
`define CSPC_OFF_PWR_MGMT    12'h020
`define CSPC_OFF_SKT_CTRL    12'h010
`define CSPC_OFF_IRQ_STATUS  12'h040
`define CSPC_OFF_IRQ_MASK    12'h044

// socket power-management fields
`define CSPC_BIT_ACCESS      25
`define CSPC_BIT_MODE        24
`define CSPC_BIT_CTRL_EN     16
`define CSPC_BIT_SLOW_SEL    0

// socket control field holding the idle stop permit
`define CSPC_BIT_STOP_PERMIT 7

// interrupt status fields
`define CSPC_IRQ_ACCESS      0
`define CSPC_IRQ_MODE        1
`define CSPC_IRQ_W           2

// reset values
`define CSPC_RST_PWR_MGMT    32'h00000000
`define CSPC_RST_STOP_PERMIT 1'b0

// slow-clock divide factor
`define CSPC_SLOW_DIV        16

`endif

// ### rtl/cspc_top.v
// card socket clock and power control: APB register slave plus idle clock
// policy that stops or slows the card clock when the socket is idle.
// assumes an APB master on sys_clk and synchronous socket status inputs.
`default_nettype none
`include "cspc_consts.vh"

module cspc_top #(
  parameter SLOW_DIV = `CSPC_SLOW_DIV
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        card_access,
  input  wire        socket_idle,
  input  wire        host_clk_stopping,
  output reg         card_clk_en,
  output reg         card_clk_stopped,
  output reg         card_clk_slowed,
  output reg         irq
);
  // idle clock states
  localparam ST_RUN  = 3'b001;
  localparam ST_STOP = 3'b010;
  localparam ST_SLOW = 3'b100;

  // register state
  reg        socket_access_flag;
  reg        clock_mode_changed_flag;
  reg        idle_clock_control_enable;
  reg        idle_clock_slow_select;
  reg        socket_idle_stop_permit;
  reg [`CSPC_IRQ_W-1:0] irq_status;
  reg [`CSPC_IRQ_W-1:0] irq_mask;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [31:0] next_prdata;
  wire       div_en;

  // reset image of the power-management word, sliced per field below
  localparam [31:0] RST_PM = `CSPC_RST_PWR_MGMT;

  // address decode shared by read and write paths
  function is_reg;
    input [11:0] a;
    begin
      is_reg = (a == `CSPC_OFF_PWR_MGMT) || (a == `CSPC_OFF_SKT_CTRL) ||
               (a == `CSPC_OFF_IRQ_STATUS) || (a == `CSPC_OFF_IRQ_MASK);
    end
  endfunction

  // one-wait slave: answer in the second access cycle
  wire acc     = psel && penable && !pready;
  wire wr      = acc && pwrite && is_reg(paddr);
  wire rd      = acc && !pwrite && is_reg(paddr);
  wire rd_pm   = rd && (paddr == `CSPC_OFF_PWR_MGMT);
  wire wr_pm   = wr && (paddr == `CSPC_OFF_PWR_MGMT);
  wire wr_sc   = wr && (paddr == `CSPC_OFF_SKT_CTRL);
  wire wr_ist  = wr && (paddr == `CSPC_OFF_IRQ_STATUS);
  wire wr_imk  = wr && (paddr == `CSPC_OFF_IRQ_MASK);

  // stop or slow only allowed when the permit or the host clock agrees
  wire may_idle = socket_idle && (socket_idle_stop_permit || host_clk_stopping);
  // selection honoured only while enabled, else stop
  wire use_slow = idle_clock_control_enable && idle_clock_slow_select;

  // read mux; unused bits stay zero
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `CSPC_OFF_PWR_MGMT: begin
        next_prdata[`CSPC_BIT_ACCESS]   = socket_access_flag;
        next_prdata[`CSPC_BIT_MODE]     = clock_mode_changed_flag;
        next_prdata[`CSPC_BIT_CTRL_EN]  = idle_clock_control_enable;
        next_prdata[`CSPC_BIT_SLOW_SEL] = idle_clock_slow_select;
      end
      `CSPC_OFF_SKT_CTRL: begin
        next_prdata[`CSPC_BIT_STOP_PERMIT] = socket_idle_stop_permit;
      end
      `CSPC_OFF_IRQ_STATUS: begin
        next_prdata[`CSPC_IRQ_W-1:0] = irq_status;
      end
      `CSPC_OFF_IRQ_MASK: begin
        next_prdata[`CSPC_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // apb handshake and read data
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !is_reg(paddr); // unmapped address errors
      prdata  <= (acc && !pwrite) ? next_prdata : 32'h00000000;
    end
  end

  // control bits; reserved bits have no storage so writes vanish
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      idle_clock_control_enable <= RST_PM[`CSPC_BIT_CTRL_EN];
      idle_clock_slow_select    <= RST_PM[`CSPC_BIT_SLOW_SEL];
      socket_idle_stop_permit   <= `CSPC_RST_STOP_PERMIT;
      irq_mask                  <= {`CSPC_IRQ_W{1'b0}};
    end else begin
      if (wr_pm) begin
        idle_clock_control_enable <= pwdata[`CSPC_BIT_CTRL_EN];
        idle_clock_slow_select    <= pwdata[`CSPC_BIT_SLOW_SEL];
      end
      if (wr_sc)
        socket_idle_stop_permit <= pwdata[`CSPC_BIT_STOP_PERMIT];
      if (wr_imk)
        irq_mask <= pwdata[`CSPC_IRQ_W-1:0];
    end
  end

  // access flag: a new access in the clearing read wins over the clear
  always @(posedge sys_clk) begin
    if (!rst_n)
      socket_access_flag <= 1'b0;
    else if (card_access)
      socket_access_flag <= 1'b1;
    else if (rd_pm)
      socket_access_flag <= 1'b0;
  end

  // idle clock state machine
  always @* begin
    case (state)
      ST_RUN: begin
        if (may_idle)
          next_state = use_slow ? ST_SLOW : ST_STOP;
        else
          next_state = ST_RUN;
      end
      ST_STOP, ST_SLOW: begin
        // leave idle on any access or when idle conditions lapse
        if (!may_idle || card_access)
          next_state = ST_RUN;
        else
          next_state = state;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // mode flag follows the clock state, registered
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_mode_changed_flag <= 1'b0;
      card_clk_stopped        <= 1'b0;
      card_clk_slowed         <= 1'b0;
    end else begin
      clock_mode_changed_flag <= (next_state != ST_RUN);
      card_clk_stopped        <= (next_state == ST_STOP);
      card_clk_slowed         <= (next_state == ST_SLOW);
    end
  end

  // card clock enable strobe, divided by the slow factor only in ST_SLOW
  cspc_clk_div #(
    .DIV (SLOW_DIV)
  ) u_div (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .run         (state == ST_RUN),
    .slow        (state == ST_SLOW),
    .card_clk_en (div_en)
  );

  always @(posedge sys_clk) begin
    if (!rst_n)
      card_clk_en <= 1'b0;
    else
      card_clk_en <= div_en;
  end

  // sticky interrupt status, write one to clear; a new event beats the clear
  wire mode_rise = (next_state != ST_RUN) && !clock_mode_changed_flag;
  wire [`CSPC_IRQ_W-1:0] ev = {mode_rise, card_access};
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_status <= {`CSPC_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_status <= ev | (irq_status & ~(wr_ist ? pwdata[`CSPC_IRQ_W-1:0] : 2'b00));
      irq <= |((ev | (irq_status & ~(wr_ist ? pwdata[`CSPC_IRQ_W-1:0] : 2'b00))) & irq_mask);
    end
  end

endmodule

`default_nettype wire

// ### tb/card_socket_clock_power_control_tb.sv
// self-checking bench for the socket clock control block
// assumes cspc_top and cspc_card on one 20 MHz clock
`default_nettype none
module card_socket_clock_power_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        host_clk_stopping = 1'h0, busy = 1'h1, poke = 1'h0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd, n, lf = 32'h3d;
  wire         pready, pslverr, card_access, socket_idle, irq;
  wire         card_clk_en, card_clk_stopped, card_clk_slowed;
  wire  [31:0] prdata;
  int          errors = 0, checks = 0;

  // 50 ns period
  always #25 sys_clk = !sys_clk;
  cspc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_access(card_access), .socket_idle(socket_idle),
    .host_clk_stopping(host_clk_stopping), .card_clk_en(card_clk_en),
    .card_clk_stopped(card_clk_stopped), .card_clk_slowed(card_clk_slowed), .irq(irq));
  cspc_card card (.sys_clk(sys_clk), .rst_n(rst_n), .busy(busy), .poke(poke),
    .card_access(card_access), .socket_idle(socket_idle));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // card clock pulses expected in 32 idle cycles for each idle action
  function automatic logic [31:0] ens(input logic [1:0] st);
    return st == 2'h2 ? 32'h0 : st == 2'h1 ? 32'h2 : 32'h20;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; waits for pready under a bound, data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'h1 && t < 20);
    if (t == 20) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // card goes quiet: check idle action, clock pulses and mode flag
  task automatic idle_try(input logic [31:0] cfg, input logic [1:0] st);
    apb(1'h1, 12'h020, cfg);
    busy <= 1'h0;
    repeat (8) @(posedge sys_clk);
    chk({card_clk_stopped, card_clk_slowed}, st);
    n = 32'h0;
    repeat (32) @(posedge sys_clk) n += card_clk_en;
    chk(n, ens(st));
    apb(1'h0, 12'h020, 32'h0);
    chk(rd[24], st != 2'h0);
    busy <= 1'h1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reset, random register traffic, access flag, irq, idle policies
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    repeat (6) begin
      lf = lfsr(lf);
      apb(1'h1, 12'h020, lf);
      apb(1'h0, 12'h020, 32'h0);
      chk(rd, lf & 32'h00010001);
    end
    apb(1'h1, 12'h044, 32'h1);
    poke <= 1'h1;
    @(posedge sys_clk);
    poke <= 1'h0;
    repeat (4) @(posedge sys_clk);
    chk(irq, 1'h1);
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, (lf & 32'h00010001) | 32'h02000000);
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, lf & 32'h00010001);
    apb(1'h1, 12'h040, 32'h1);
    apb(1'h0, 12'h0f0, 32'h0);
    chk({er, irq, rd[29:0]}, 32'h80000000);
    idle_try(32'h0, 2'h0);
    host_clk_stopping <= 1'h1;
    idle_try(32'h0, 2'h2);
    host_clk_stopping <= 1'h0;
    apb(1'h1, 12'h010, 32'h80);
    idle_try(32'h1, 2'h2);
    idle_try(32'h00010001, 2'h1);
    idle_try(32'h00010000, 2'h2);
    chk(irq, 1'h0);
    end_of_test;
  end

  // watchdog well beyond the expected run of under 1000 cycles
  initial begin
    #200000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire

// ### tb/cspc_card.sv
// card model: socket activity and access strobes toward the controller
// assumes sys_clk only; busy keeps the card working, poke makes one access
`default_nettype none
module cspc_card (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic busy,
  input  wire logic poke,
  output var  logic card_access,
  output var  logic socket_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle only when no work; accesses never come from an idle card
  always @(posedge sys_clk) begin
    socket_idle <= rst_n && !busy;
    card_access <= rst_n && busy && poke;
  end
endmodule
`default_nettype wire

// ### tb/cspc_chk.sv
// port assertions for the socket clock control block
// assumes a bind into cspc_top on its single clock
`default_nettype none
module cspc_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        socket_idle,
  input wire logic        card_clk_en,
  input wire logic        card_clk_stopped,
  input wire logic        card_clk_slowed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // completed read of the power-management word
  wire rd20 = psel && penable && pready && !pwrite && paddr == 12'h020;

  reserved_bits_zero_a: assert property (rd20 |-> (prdata & 32'hfcfefffe) == 32'h0)
    else $error("reserved bits set");
  pulse_one_a: assert property (pready |=> !pready)
    else $error("pready too long");
  answer_in_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  stop_gate_a: assert property (card_clk_stopped && $past(card_clk_stopped) &&
    $past(card_clk_stopped, 2) |-> !card_clk_en)
    else $error("clock runs while stopped");
  slow_gap_a: assert property (card_clk_slowed && $past(card_clk_slowed) && card_clk_en
    ##1 card_clk_slowed |-> !card_clk_en)
    else $error("slow pulses too close");
  one_mode_a: assert property (!(card_clk_stopped && card_clk_slowed))
    else $error("stop and slow together");
  idle_only_a: assert property ($rose(card_clk_stopped || card_clk_slowed) |-> $past(socket_idle))
    else $error("idle action while busy");
  mode_flag_a: assert property (rd20 && $past(card_clk_stopped, 2) && card_clk_stopped |-> prdata[24])
    else $error("mode flag low");
endmodule
bind cspc_top cspc_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .socket_idle(socket_idle), .card_clk_en(card_clk_en),
  .card_clk_stopped(card_clk_stopped), .card_clk_slowed(card_clk_slowed));
`default_nettype wire
